// ===== core/deep_sleep_clock_gate_ctrl.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
// What this block does
// - Each writable gating bit is the clock enable of one peripheral, 1 clocks it, 0 stops it.
// - An access aimed at a peripheral whose enable is 0 answers with a bus fault.
// - Reset clears every gating bit so the register reads zero and all modules are unclocked.
// - Timer enables c, b and a sit at bits 18, 17 and 16 and are read/write.
// - The two-wire serial enable is the read/write bit 12.
// - The synchronous serial enable is the read/write bit 4.
// - Asynchronous serial enables b and a are the read/write bits 1 and 0.
// - Reserved bits, 31:19, 15:13, 11:5 and 3:2, are read-only zero and ignore writes.
// - The run register gates in run, the sleep register in sleep, this register in deep sleep.
// - Sleep-mode registers apply only when the automatic gating select bit is set.
// - This register decodes at offset 0x124 from the system control base, 32-bit access.
module deep_sleep_clock_gate_ctrl #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic                                  clk_i,
  input  wire logic                                  srst_i,
  input  wire logic                                  psel_i,
  input  wire logic                                  penable_i,
  input  wire logic                                  pwrite_i,
  input  wire logic [ADDR_W-1:0]                     paddr_i,
  input  wire logic [31:0]                           pwdata_i,
  output logic      [31:0]                           prdata_o,
  output logic                                       pready_o,
  output logic                                       pslverr_o,
  input  wire logic [1:0]                            power_state_i,
  input  wire logic [gate_ctrl_pkg::NUM_GATES-1:0]   periph_access_i,
  output logic      [gate_ctrl_pkg::NUM_GATES-1:0]   periph_clk_en_o,
  output logic                                       bus_fault_o,
  output logic                                       irq_o
);

  localparam int unsigned NG = gate_ctrl_pkg::NUM_GATES;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0]   run_gate_reg_one_q;
  logic [31:0]   run_gate_reg_one_d;
  logic [31:0]   sleep_gate_reg_one_q;
  logic [31:0]   sleep_gate_reg_one_d;
  logic [31:0]   deep_sleep_gate_reg_one_q;
  logic [31:0]   deep_sleep_gate_reg_one_d;
  logic [31:0]   run_clock_config_reg_q;
  logic [31:0]   run_clock_config_reg_d;
  logic [NG-1:0] fault_en_q;
  logic [NG-1:0] fault_en_d;
  logic [31:0]   prdata_q;
  logic [31:0]   prdata_d;
  logic          pready_q;
  logic          pready_d;
  logic          pslverr_q;
  logic          pslverr_d;
  logic          bus_fault_q;
  logic          bus_fault_d;
  logic          irq_q;
  logic          irq_d;

  logic          setup;
  logic          wr_commit;
  logic [11:0]   offs;
  logic          hit;
  logic [31:0]   sel_reg;
  logic [NG-1:0] sel_en;
  logic [NG-1:0] clk_en;
  logic [NG-1:0] fault_ev;
  logic [NG-1:0] fault_clr;
  logic [NG-1:0] fault_stat;
  logic          auto_gating_select;

  assign setup     = psel_i & ~penable_i;
  assign wr_commit = psel_i & penable_i & pready_q & pwrite_i;
  assign offs      = 12'(paddr_i);
  assign auto_gating_select = run_clock_config_reg_q[gate_ctrl_pkg::AUTO_GATING_POS];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    unique case (offs)
      gate_ctrl_pkg::RUN_CLOCK_CFG_OFF,
      gate_ctrl_pkg::RUN_GATE_OFF,
      gate_ctrl_pkg::SLEEP_GATE_OFF,
      gate_ctrl_pkg::DEEP_GATE_OFF,
      gate_ctrl_pkg::FAULT_STATUS_OFF,
      gate_ctrl_pkg::FAULT_ENABLE_OFF,
      gate_ctrl_pkg::FAULT_CLEAR_OFF: hit = 1'b1;
      default:                        hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_comb begin
    run_gate_reg_one_d        = run_gate_reg_one_q;
    sleep_gate_reg_one_d      = sleep_gate_reg_one_q;
    deep_sleep_gate_reg_one_d = deep_sleep_gate_reg_one_q;
    run_clock_config_reg_d    = run_clock_config_reg_q;
    fault_en_d                = fault_en_q;
    fault_clr                 = '0;
    if (wr_commit) begin
      unique case (offs)
        gate_ctrl_pkg::RUN_GATE_OFF:
          run_gate_reg_one_d = pwdata_i & gate_ctrl_pkg::GATE_WRITABLE_MASK;
        gate_ctrl_pkg::SLEEP_GATE_OFF:
          sleep_gate_reg_one_d = pwdata_i & gate_ctrl_pkg::GATE_WRITABLE_MASK;
        gate_ctrl_pkg::DEEP_GATE_OFF:
          deep_sleep_gate_reg_one_d = pwdata_i & gate_ctrl_pkg::GATE_WRITABLE_MASK;
        gate_ctrl_pkg::RUN_CLOCK_CFG_OFF:
          run_clock_config_reg_d = pwdata_i & gate_ctrl_pkg::CFG_WRITABLE_MASK;
        gate_ctrl_pkg::FAULT_ENABLE_OFF:
          fault_en_d = pwdata_i[NG-1:0];
        gate_ctrl_pkg::FAULT_CLEAR_OFF:
          fault_clr = pwdata_i[NG-1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus answer, registered in the setup cycle
  // ----------------------------------------------------------------
  always_comb begin
    pready_d  = setup;
    pslverr_d = setup & ~hit;
    prdata_d  = '0;
    if (setup & ~pwrite_i) begin
      unique case (offs)
        gate_ctrl_pkg::RUN_CLOCK_CFG_OFF: prdata_d = run_clock_config_reg_q;
        gate_ctrl_pkg::RUN_GATE_OFF:      prdata_d = run_gate_reg_one_q;
        gate_ctrl_pkg::SLEEP_GATE_OFF:    prdata_d = sleep_gate_reg_one_q;
        gate_ctrl_pkg::DEEP_GATE_OFF:     prdata_d = deep_sleep_gate_reg_one_q;
        gate_ctrl_pkg::FAULT_STATUS_OFF:  prdata_d = 32'(fault_stat);
        gate_ctrl_pkg::FAULT_ENABLE_OFF:  prdata_d = 32'(fault_en_q);
        default:                          prdata_d = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power state selection of enables
  // ----------------------------------------------------------------
  always_comb begin
    sel_reg = run_gate_reg_one_q;
    if (auto_gating_select) begin
      unique case (power_state_i)
        gate_ctrl_pkg::PWR_SLEEP: sel_reg = sleep_gate_reg_one_q;
        gate_ctrl_pkg::PWR_DEEP:  sel_reg = deep_sleep_gate_reg_one_q;
        default:                  sel_reg = run_gate_reg_one_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-gate selection and fault events
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NG; g++) begin : g_gate
    assign sel_en[g]   = sel_reg[gate_ctrl_pkg::GATE_POS[g]];
    assign fault_ev[g] = periph_access_i[g] & ~clk_en[g];
  end

  // ----------------------------------------------------------------
  // Clock enable cells
  // ----------------------------------------------------------------
  gate_enable_cell async_serial_a_cell (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .sel_en_i (sel_en[0]),
    .clk_en_o (clk_en[0])
  );

  gate_enable_cell async_serial_b_cell (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .sel_en_i (sel_en[1]),
    .clk_en_o (clk_en[1])
  );

  gate_enable_cell sync_serial_cell (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .sel_en_i (sel_en[2]),
    .clk_en_o (clk_en[2])
  );

  gate_enable_cell two_wire_cell (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .sel_en_i (sel_en[3]),
    .clk_en_o (clk_en[3])
  );

  gate_enable_cell gp_timer_a_cell (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .sel_en_i (sel_en[4]),
    .clk_en_o (clk_en[4])
  );

  gate_enable_cell gp_timer_b_cell (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .sel_en_i (sel_en[5]),
    .clk_en_o (clk_en[5])
  );

  gate_enable_cell gp_timer_c_cell (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .sel_en_i (sel_en[6]),
    .clk_en_o (clk_en[6])
  );

  // ----------------------------------------------------------------
  // Fault status flags
  // ----------------------------------------------------------------
  sticky_flag async_serial_a_flag (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .set_i  (fault_ev[0]),
    .clr_i  (fault_clr[0]),
    .flag_o (fault_stat[0])
  );

  sticky_flag async_serial_b_flag (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .set_i  (fault_ev[1]),
    .clr_i  (fault_clr[1]),
    .flag_o (fault_stat[1])
  );

  sticky_flag sync_serial_flag (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .set_i  (fault_ev[2]),
    .clr_i  (fault_clr[2]),
    .flag_o (fault_stat[2])
  );

  sticky_flag two_wire_flag (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .set_i  (fault_ev[3]),
    .clr_i  (fault_clr[3]),
    .flag_o (fault_stat[3])
  );

  sticky_flag gp_timer_a_flag (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .set_i  (fault_ev[4]),
    .clr_i  (fault_clr[4]),
    .flag_o (fault_stat[4])
  );

  sticky_flag gp_timer_b_flag (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .set_i  (fault_ev[5]),
    .clr_i  (fault_clr[5]),
    .flag_o (fault_stat[5])
  );

  sticky_flag gp_timer_c_flag (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .set_i  (fault_ev[6]),
    .clr_i  (fault_clr[6]),
    .flag_o (fault_stat[6])
  );

  always_comb begin
    bus_fault_d = |fault_ev;
    irq_d       = |(fault_stat & fault_en_q);
  end

  // ----------------------------------------------------------------
  // Gating and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      run_gate_reg_one_q        <= gate_ctrl_pkg::GATE_RESET;
      sleep_gate_reg_one_q      <= gate_ctrl_pkg::GATE_RESET;
      deep_sleep_gate_reg_one_q <= gate_ctrl_pkg::GATE_RESET;
      run_clock_config_reg_q    <= gate_ctrl_pkg::CFG_RESET;
    end else begin
      run_gate_reg_one_q        <= run_gate_reg_one_d;
      sleep_gate_reg_one_q      <= sleep_gate_reg_one_d;
      deep_sleep_gate_reg_one_q <= deep_sleep_gate_reg_one_d;
      run_clock_config_reg_q    <= run_clock_config_reg_d;
    end
  end

  // ----------------------------------------------------------------
  // Fault enable register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fault_en_q <= gate_ctrl_pkg::FAULT_RESET;
    end else begin
      fault_en_q <= fault_en_d;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Fault and interrupt outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bus_fault_q <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      bus_fault_q <= bus_fault_d;
      irq_q       <= irq_d;
    end
  end

  assign prdata_o        = prdata_q;
  assign pready_o        = pready_q;
  assign pslverr_o       = pslverr_q;
  assign periph_clk_en_o = clk_en;
  assign bus_fault_o     = bus_fault_q;
  assign irq_o           = irq_q;

endmodule : deep_sleep_clock_gate_ctrl

// ===== core/gate_ctrl_pkg.sv
package gate_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] RUN_CLOCK_CFG_OFF  = 12'h060;
  localparam logic [11:0] RUN_GATE_OFF       = 12'h104;
  localparam logic [11:0] SLEEP_GATE_OFF     = 12'h114;
  localparam logic [11:0] DEEP_GATE_OFF      = 12'h124;
  localparam logic [11:0] FAULT_STATUS_OFF   = 12'h200;
  localparam logic [11:0] FAULT_ENABLE_OFF   = 12'h204;
  localparam logic [11:0] FAULT_CLEAR_OFF    = 12'h208;
  localparam logic [31:0] SYSCTL_BASE        = 32'h400f_e000;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int unsigned NUM_GATES          = 7;
  localparam int unsigned GP_TIMER_C_POS     = 18;
  localparam int unsigned GP_TIMER_B_POS     = 17;
  localparam int unsigned GP_TIMER_A_POS     = 16;
  localparam int unsigned TWO_WIRE_POS       = 12;
  localparam int unsigned SYNC_SERIAL_POS    = 4;
  localparam int unsigned ASYNC_SERIAL_B_POS = 1;
  localparam int unsigned ASYNC_SERIAL_A_POS = 0;
  localparam int unsigned AUTO_GATING_POS    = 27;
  localparam logic [31:0] GATE_WRITABLE_MASK = 32'h0007_1013;
  localparam logic [31:0] CFG_WRITABLE_MASK  = 32'h0800_0000;

  // Enable index i maps to this register bit
  localparam int unsigned GATE_POS [NUM_GATES] = '{
    ASYNC_SERIAL_A_POS, ASYNC_SERIAL_B_POS, SYNC_SERIAL_POS, TWO_WIRE_POS,
    GP_TIMER_A_POS, GP_TIMER_B_POS, GP_TIMER_C_POS
  };

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] GATE_RESET         = 32'h0000_0000;
  localparam logic [31:0] CFG_RESET          = 32'h0000_0000;
  localparam logic [6:0]  FAULT_RESET        = 7'h00;

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_RUN   = 2'h0,
    PWR_SLEEP = 2'h1,
    PWR_DEEP  = 2'h3
  } power_state_t;

endpackage : gate_ctrl_pkg

// ===== core/gate_enable_cell.sv
`timescale 1ns/1ps
module gate_enable_cell (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic sel_en_i,
  output logic      clk_en_o
);

  logic en_d;
  logic en_q;

  // ----------------------------------------------------------------
  // Enable register, changes only at a clock edge
  // ----------------------------------------------------------------
  always_comb begin
    en_d = sel_en_i;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en_d;
    end
  end

  assign clk_en_o = en_q;

endmodule : gate_enable_cell

// ===== core/sticky_flag.sv
`timescale 1ns/1ps
module sticky_flag (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  logic flag_d;
  logic flag_q;

  // ----------------------------------------------------------------
  // Set wins over clear
  // ----------------------------------------------------------------
  always_comb begin
    flag_d = flag_q;
    if (clr_i) begin
      flag_d = 1'b0;
    end
    if (set_i) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule : sticky_flag

// ===== tb/deep_sleep_clock_gate_ctrl_tb.sv
`timescale 1ns/1ps
module deep_sleep_clock_gate_ctrl_tb;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, fault, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  pstate;
  logic [6:0]  acc, en;
  int          mismatches, checks, cyc;
  int unsigned pos [7] = '{0, 1, 4, 12, 16, 17, 18};

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  deep_sleep_clock_gate_ctrl deep_sleep_clock_gate_ctrl_i (
    .clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .power_state_i(pstate), .periph_access_i(acc),
    .periph_clk_en_o(en), .bus_fault_o(fault), .irq_o(irq));
  periph_model periph_model_i (.clk_i(clk), .access_o(acc));

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk(pready, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(err, 32'h0);
  endtask : wr

  task rdchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(err, eerr);
  endtask : rdchk

  task settle;
    repeat (2) @(posedge clk);
  endtask : settle

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      summarize;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata, pstate} = {1'b1, 49'h0};
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rdchk(12'h124, 32'h0, 1'b0);
    rdchk(gate_ctrl_pkg::RUN_GATE_OFF, 32'h0, 1'b0);
    rdchk(gate_ctrl_pkg::FAULT_STATUS_OFF, 32'h0, 1'b0);
    rdchk(12'h300, 32'h0, 1'b1);
    wr(12'h124, 32'hffff_ffff);
    rdchk(12'h124, 32'h0007_1013, 1'b0);
    wr(gate_ctrl_pkg::RUN_CLOCK_CFG_OFF, 32'h0800_0000);
    pstate <= 2'h3;
    settle;
    chk(en, 7'h7f);
    for (int i = 0; i < 7; i++) begin
      wr(12'h124, (32'h1 << pos[i]) | 32'h0000_000c);
      settle;
      chk(en, 7'h01 << i);
      rdchk(12'h124, 32'h1 << pos[i], 1'b0);
    end
    wr(gate_ctrl_pkg::RUN_GATE_OFF, 32'h1);
    wr(gate_ctrl_pkg::SLEEP_GATE_OFF, 32'h2);
    pstate <= 2'h1;
    settle;
    chk(en, 7'h02);
    pstate <= 2'h0;
    settle;
    chk(en, 7'h01);
    wr(gate_ctrl_pkg::RUN_CLOCK_CFG_OFF, 32'h0);
    pstate <= 2'h3;
    settle;
    chk(en, 7'h01);
    wr(gate_ctrl_pkg::FAULT_ENABLE_OFF, 32'h7f);
    periph_model_i.touch(0);
    @(posedge clk);
    chk(fault, 32'h0);
    periph_model_i.touch(3);
    @(posedge clk);
    chk(fault, 32'h1);
    @(posedge clk);
    chk(irq, 32'h1);
    wr(gate_ctrl_pkg::FAULT_ENABLE_OFF, 32'h0);
    settle;
    chk(irq, 32'h0);
    rdchk(gate_ctrl_pkg::FAULT_STATUS_OFF, 32'h8, 1'b0);
    wr(gate_ctrl_pkg::FAULT_ENABLE_OFF, 32'h7f);
    wr(gate_ctrl_pkg::FAULT_CLEAR_OFF, 32'h8);
    settle;
    chk(irq, 32'h0);
    rdchk(gate_ctrl_pkg::FAULT_STATUS_OFF, 32'h0, 1'b0);
    srst <= 1'b1;
    settle;
    srst <= 1'b0;
    rdchk(12'h124, 32'h0, 1'b0);
    chk(en, 32'h0);
    summarize;
  end
endmodule : deep_sleep_clock_gate_ctrl_tb

// ===== tb/gate_chk.sv
`timescale 1ns/1ps
module gate_chk #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic              clk_i,
  input wire logic              srst_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic [1:0]        power_state_i,
  input wire logic [6:0]        periph_access_i,
  input wire logic [6:0]        periph_clk_en_o,
  input wire logic              bus_fault_o,
  input wire logic              irq_o
);
  // ----------------------------------------
  // Protocol and gating checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence gated_hit_s;
    |(periph_access_i & ~periph_clk_en_o);
  endsequence
  a_ready_after_setup: assert property (setup_s |=> pready_o)
    else $error("no ready after setup");
  a_ready_has_setup: assert property (pready_o |-> $past(psel_i && !penable_i))
    else $error("ready without setup");
  a_fault_on_gated: assert property (gated_hit_s |=> bus_fault_o)
    else $error("missing bus fault");
  a_fault_has_cause: assert property (bus_fault_o |-> $past(|(periph_access_i & ~periph_clk_en_o)))
    else $error("spurious bus fault");
  a_reset_clears_all: assert property ($fell(srst_i) |-> !periph_clk_en_o && !irq_o && !prdata_o)
    else $error("outputs not clear after reset");
  a_enable_change_cause: assert property ($changed(periph_clk_en_o) |->
    $past(psel_i && penable_i && pwrite_i, 2) || $past(power_state_i) != $past(power_state_i, 2))
    else $error("enable changed without cause");
  a_error_reads_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error response with data");
  a_reserved_read_zero: assert property (pready_o && $past(!pwrite_i && paddr_i == 12'h124)
    |-> (prdata_o & 32'hfff8_efec) == 32'h0)
    else $error("reserved bits read nonzero");
  a_irq_rise_cause: assert property ($rose(irq_o) |->
    $past(bus_fault_o) || $past(psel_i && penable_i && pwrite_i, 2))
    else $error("interrupt rose without cause");
endmodule : gate_chk

bind deep_sleep_clock_gate_ctrl gate_chk #(.ADDR_W(ADDR_W)) gate_chk_i (
  .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .power_state_i(power_state_i),
  .periph_access_i(periph_access_i), .periph_clk_en_o(periph_clk_en_o),
  .bus_fault_o(bus_fault_o), .irq_o(irq_o)
);

// ===== tb/periph_model.sv
`timescale 1ns/1ps
module periph_model (
  input wire logic  clk_i,
  output logic [6:0] access_o
);
  // ----------------------------------------
  // Peripheral access attempts
  // ----------------------------------------
  initial access_o = 7'h00;
  task automatic touch(input int unsigned idx);
    @(posedge clk_i);
    access_o <= 7'h01 << idx;
    @(posedge clk_i);
    access_o <= 7'h00;
  endtask : touch
endmodule : periph_model
